// >>> core/sbe_pkg.sv
package sbe_pkg;

   // Widths of the data path and the clock divider, and the receive buffer depth.
   localparam int unsigned SBE_BYTE_W = 8;
   localparam int unsigned SBE_PRE_W  = 6;
   localparam int unsigned SBE_DEPTH  = 2;

   typedef logic [SBE_BYTE_W-1:0] sbe_byte_t;
   typedef logic [SBE_PRE_W-1:0]  sbe_pre_t;
   typedef logic [2:0]            sbe_idx_t;
   typedef logic [1:0]            sbe_cnt_t;
   typedef logic [3:0]            sbe_pulse_t;

   // Bit positions within a byte and the step between them.
   localparam sbe_idx_t SBE_FIRST_BIT = 3'h0;
   localparam sbe_idx_t SBE_LAST_BIT  = 3'h7;
   localparam sbe_idx_t SBE_IDX_STEP  = 3'h1;

   // Receive buffer fill levels.
   localparam sbe_cnt_t SBE_CNT_EMPTY = 2'h0;
   localparam sbe_cnt_t SBE_CNT_ONE   = 2'h1;
   localparam sbe_cnt_t SBE_CNT_FULL  = 2'h2;

   // Serial clock pulses in one byte cycle.
   localparam sbe_pulse_t SBE_PULSES     = 4'h8;
   localparam sbe_pulse_t SBE_PULSE_STEP = 4'h1;
   localparam sbe_pulse_t SBE_PULSE_RST  = 4'h0;

   // Divider preload values.
   localparam sbe_pre_t SBE_PRE_ZERO = 6'h00;
   localparam sbe_pre_t SBE_PRE_STEP = 6'h01;

   // Mode encodings and reset values.
   localparam logic      SBE_FULL_DUPLEX = 1'b0;
   localparam logic      SBE_MSB_FIRST   = 1'b0;
   localparam logic      SBE_EMPTY_RST   = 1'b1;
   localparam logic      SBE_BIT_RST     = 1'b0;
   localparam sbe_byte_t SBE_BYTE_RST    = 8'h00;
   localparam logic [2:0] SBE_SYNC3_RST  = 3'h0;
   localparam logic [1:0] SBE_SYNC2_RST  = 2'h0;

   // Link-side shifter states.
   typedef enum logic {
      SBE_IDLE,
      SBE_SHIFT
   } sbe_link_e;

endpackage : sbe_pkg

// >>> core/sbe_top.sv
// Behaviour
// RULE1: Nothing moves, no flag changes and no clock is made until the enable input is set.
// RULE2: With duplex select at 0 each bit is shifted out and sampled in within the same serial clock.
// RULE3: Software sets polarity and both phase inputs to suit the slave; all at 0 suit an EEPROM.
// RULE4: With bit order select at 0 every byte goes out and comes in most significant bit first.
// RULE5: A write of the transmit byte clears the transmit-empty flag.
// RULE6: A byte written while the shifter is idle is moved into it and transmit-empty is set again.
// RULE7: While a byte is shifting the block drives the serial clock and data out and samples data in.
// RULE8: A byte written while shifting waits in the holding register until the shift is over.
// RULE9: After 8 serial clock pulses the cycle ends, receive-full is set and the enabled interrupt rises.
// RULE10: At the end of a cycle a pending byte is loaded, transmit-empty is set and shifting restarts.
// RULE11: Software reads the receive byte before the next write, and that read clears receive-full; here only a read that empties the buffer does.
// RULE12: At each cycle end the receive register holds the 8 bits sampled during that cycle; here an unread byte stays shown and the new one queues behind it.
// RULE13: Software writes one dummy byte per byte it wants to receive, since only writes start shifts.
// RULE14: Software drives the active-low chip select on a general pin; this block has none.
// RULE15: With no further byte the block goes idle after the last cycle and software ends the frame.
// RULE16: The serial clock comes from a 6-bit down counter reloaded from the preload; zero bypasses it.
// RULE17: At reset or while disabled transmit-empty is set, receive-full clear and the interrupt low.
`timescale 1ns/1ns
`default_nettype none
module sbe_top (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              link_clk_i,
   input  wire logic              link_rst_i,
   input  wire logic              block_enable_reg_i,
   input  wire logic              duplex_select_i,
   input  wire logic              clock_polarity_sel_i,
   input  wire logic              tx_clock_phase_i,
   input  wire logic              rx_clock_phase_i,
   input  wire logic              bit_order_sel_i,
   input  wire sbe_pkg::sbe_pre_t preload_i,
   input  wire logic              irq_enable_i,
   input  wire sbe_pkg::sbe_byte_t tx_data_reg_i,
   input  wire logic              tx_write_i,
   input  wire logic              rx_read_i,
   input  wire logic              serial_in_pin_i,
   output logic                   tx_empty_flag_o,
   output logic                   rx_full_flag_o,
   output sbe_pkg::sbe_byte_t     rx_data_reg_o,
   output logic                   xfer_irq_o,
   output logic                   busy_o,
   output logic                   serial_clock_pin_o,
   output logic                   serial_out_pin_o
);
   import sbe_pkg::*;

   // Position in the byte of the k-th bit on the wire.
   function automatic sbe_idx_t bit_pos(input logic order, input sbe_idx_t k);
      bit_pos = (order == SBE_MSB_FIRST) ? sbe_idx_t'(SBE_LAST_BIT - k) : k;
   endfunction : bit_pos

   // Reload value of the divider; zero means toggle on every link edge.
   function automatic sbe_pre_t reload(input sbe_pre_t pre);
      reload = (pre == SBE_PRE_ZERO) ? SBE_PRE_ZERO : sbe_pre_t'(pre - SBE_PRE_STEP);
   endfunction : reload

   // ---------------- System clock domain ----------------
   logic        sys_en;
   logic        hold_v_q;
   sbe_byte_t   hold_q;
   logic        busy_q;
   logic        start_tgl_q;
   sbe_byte_t   xbyte_q;
   logic [3:0]  xmode_q;
   sbe_pre_t    xpre_q;
   logic [2:0]  done_sync_q;
   sbe_cnt_t    cnt_q;
   sbe_cnt_t    cnt_d;
   sbe_cnt_t    wr_idx;
   sbe_byte_t   buf_q [SBE_DEPTH];
   logic        tx_empty_q;
   logic        rx_full_q;
   logic        irq_q;
   logic        space;
   logic        sys_start;
   logic        sys_done;
   logic        pop;
   logic        done_tgl_q;
   sbe_byte_t   rbyte_q;

   // Software bits come from logic on this clock, so no synchroniser.
   assign sys_en    = block_enable_reg_i;                  // [RULE1]
   assign space     = (cnt_q != SBE_CNT_FULL);
   // A full receive buffer stalls the next load, so no word is lost.
   assign sys_start = sys_en & ~busy_q & hold_v_q & space
                    & (duplex_select_i == SBE_FULL_DUPLEX); // [RULE2] [RULE6]
   assign sys_done  = sys_en & busy_q & (done_sync_q[2] ^ done_sync_q[1]);
   assign pop       = rx_read_i & (cnt_q != SBE_CNT_EMPTY);
   assign wr_idx    = sbe_cnt_t'(cnt_q - (pop ? SBE_CNT_ONE : SBE_CNT_EMPTY));

   // Holding register; a write while shifting just waits here.
   always_ff @(posedge clk_i) begin
      if (rst_i || !sys_en) begin
         hold_v_q <= SBE_BIT_RST;
         hold_q   <= SBE_BYTE_RST;
      end else if (tx_write_i) begin
         hold_v_q <= 1'b1;
         hold_q   <= tx_data_reg_i;                        // [RULE8]
      end else if (sys_start) begin
         hold_v_q <= SBE_BIT_RST;                          // [RULE10]
      end
   end

   // Transmit-empty: a write clears it and wins over a load in the same cycle.
   always_ff @(posedge clk_i) begin
      if (rst_i || !sys_en) begin
         tx_empty_q <= SBE_EMPTY_RST;                      // [RULE17]
      end else if (tx_write_i) begin
         tx_empty_q <= 1'b0;                               // [RULE5]
      end else if (sys_start) begin
         tx_empty_q <= 1'b1;                               // [RULE6] [RULE10]
      end
   end

   // Busy spans a byte cycle from load until the link reports its end.
   always_ff @(posedge clk_i) begin
      if (rst_i || !sys_en) begin
         busy_q <= SBE_BIT_RST;
      end else if (sys_start) begin
         busy_q <= 1'b1;
      end else if (sys_done) begin
         busy_q <= SBE_BIT_RST;                            // [RULE15]
      end
   end

   // Byte and mode are held steady while the toggle crosses to the link.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_tgl_q <= SBE_BIT_RST;
         xbyte_q     <= SBE_BYTE_RST;
         xmode_q     <= '0;
         xpre_q      <= SBE_PRE_ZERO;
      end else if (sys_start) begin
         start_tgl_q <= ~start_tgl_q;
         xbyte_q     <= hold_q;
         xmode_q     <= {clock_polarity_sel_i, tx_clock_phase_i,
                         rx_clock_phase_i, bit_order_sel_i}; // [RULE3]
         xpre_q      <= preload_i;
      end
   end

   // Done toggle from the link; stage 0 is read only by stage 1.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_sync_q <= SBE_SYNC3_RST;
      end else begin
         done_sync_q <= {done_sync_q[1:0], done_tgl_q};
      end
   end

   // Fill level; a push and a pop in one cycle both count.
   always_comb begin
      cnt_d = cnt_q;
      if (!sys_en) begin
         cnt_d = SBE_CNT_EMPTY;
      end else if (sys_done && !pop) begin
         cnt_d = sbe_cnt_t'(cnt_q + SBE_CNT_ONE);
      end else if (pop && !sys_done) begin
         cnt_d = sbe_cnt_t'(cnt_q - SBE_CNT_ONE);          // [RULE11]
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= SBE_CNT_EMPTY;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // Two-entry receive buffer; entry 0 is the head that software sees.
   for (genvar i = 0; i < SBE_DEPTH; i++) begin : g_rxbuf
      localparam sbe_cnt_t IDX = sbe_cnt_t'(i);
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            buf_q[i] <= SBE_BYTE_RST;
         end else if (sys_done && wr_idx == IDX) begin
            buf_q[i] <= rbyte_q;                           // [RULE12]
         end else if (pop) begin
            buf_q[i] <= buf_q[(i + 1) % SBE_DEPTH];
         end
      end
   end

   // Flags and interrupt are registered from the next fill level.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_full_q <= SBE_BIT_RST;
         irq_q     <= SBE_BIT_RST;                         // [RULE17]
      end else begin
         rx_full_q <= (cnt_d != SBE_CNT_EMPTY);            // [RULE9]
         irq_q     <= sys_en & irq_enable_i & (cnt_d != SBE_CNT_EMPTY);
      end
   end

   assign tx_empty_flag_o = tx_empty_q;
   assign rx_full_flag_o  = rx_full_q;
   assign rx_data_reg_o   = buf_q[0];
   assign xfer_irq_o      = irq_q;
   assign busy_o          = busy_q;

   // ---------------- Link clock domain ----------------
   sbe_link_e   state_q;
   logic [2:0]  st_sync_q;
   logic [1:0]  en_sync_q;
   logic [1:0]  cpol_sync_q;
   logic [1:0]  miso_sync_q;
   logic        en_l;
   logic        go;
   logic        c_cpol_q;
   logic        c_txph_q;
   logic        c_rxph_q;
   logic        c_order_q;
   sbe_pre_t    c_pre_q;
   sbe_pre_t    div_q;
   sbe_idx_t    k_q;
   logic        lead_q;
   logic        sclk_q;
   logic        mosi_q;
   sbe_byte_t   tbyte_q;
   sbe_pulse_t  pulse_q;
   logic        tick;
   logic        lead_tick;
   logic        trail_tick;
   logic        last;
   logic        samp_now;
   logic [1:0]  samp_q;
   logic [1:0]  fin_q;
   sbe_idx_t    sidx1_q;
   sbe_idx_t    sidx2_q;

   // Level and toggle synchronisers; first stages feed only second stages.
   always_ff @(posedge link_clk_i) begin
      if (link_rst_i) begin
         st_sync_q   <= SBE_SYNC3_RST;
         en_sync_q   <= SBE_SYNC2_RST;
         cpol_sync_q <= SBE_SYNC2_RST;
         miso_sync_q <= SBE_SYNC2_RST;
      end else begin
         st_sync_q   <= {st_sync_q[1:0], start_tgl_q};
         en_sync_q   <= {en_sync_q[0], block_enable_reg_i};
         cpol_sync_q <= {cpol_sync_q[0], clock_polarity_sel_i};
         miso_sync_q <= {miso_sync_q[0], serial_in_pin_i};
      end
   end

   assign en_l       = en_sync_q[1];
   assign go         = en_l & (st_sync_q[2] ^ st_sync_q[1]);
   assign tick       = (c_pre_q == SBE_PRE_ZERO) | (div_q == SBE_PRE_ZERO);
   assign lead_tick  = (state_q == SBE_SHIFT) & tick & lead_q;
   assign trail_tick = (state_q == SBE_SHIFT) & tick & ~lead_q;
   assign last       = trail_tick & (k_q == SBE_LAST_BIT);

   // Shifter state; disabling aborts a byte in flight.
   always_ff @(posedge link_clk_i) begin
      if (link_rst_i || !en_l) begin
         state_q <= SBE_IDLE;                              // [RULE1]
      end else begin
         unique case (state_q)
            SBE_IDLE:  if (go) state_q <= SBE_SHIFT;       // [RULE7]
            SBE_SHIFT: if (last) state_q <= SBE_IDLE;      // [RULE9] [RULE15]
         endcase
      end
   end

   // Mode and byte are latched once, at the start of the byte.
   always_ff @(posedge link_clk_i) begin
      if (link_rst_i) begin
         {c_cpol_q, c_txph_q, c_rxph_q, c_order_q} <= '0;
         c_pre_q <= SBE_PRE_ZERO;
         tbyte_q <= SBE_BYTE_RST;
      end else if (go) begin
         {c_cpol_q, c_txph_q, c_rxph_q, c_order_q} <= xmode_q;
         c_pre_q <= xpre_q;
         tbyte_q <= xbyte_q;
      end
   end

   // Down counter sets the half period of the serial clock.
   always_ff @(posedge link_clk_i) begin
      if (link_rst_i) begin
         div_q <= SBE_PRE_ZERO;
      end else if (go) begin
         div_q <= reload(xpre_q);                          // [RULE16]
      end else if (state_q == SBE_SHIFT) begin
         div_q <= tick ? reload(c_pre_q) : sbe_pre_t'(div_q - SBE_PRE_STEP);
      end
   end

   // Bit counter and half-period phase.
   always_ff @(posedge link_clk_i) begin
      if (link_rst_i) begin
         k_q    <= SBE_FIRST_BIT;
         lead_q <= 1'b1;
      end else if (go) begin
         k_q    <= SBE_FIRST_BIT;
         lead_q <= 1'b1;
      end else if (trail_tick) begin
         k_q    <= sbe_idx_t'(k_q + SBE_IDX_STEP);
         lead_q <= 1'b1;
      end else if (lead_tick) begin
         lead_q <= 1'b0;
      end
   end

   // Serial clock rests at the polarity level outside a byte.
   always_ff @(posedge link_clk_i) begin
      if (link_rst_i) begin
         sclk_q <= SBE_BIT_RST;
      end else if (state_q == SBE_IDLE || !en_l) begin
         sclk_q <= cpol_sync_q[1];                         // [RULE15]
      end else if (lead_tick) begin
         sclk_q <= ~c_cpol_q;                              // [RULE7]
      end else if (trail_tick) begin
         sclk_q <= c_cpol_q;
      end
   end

   // Data out: phase 0 presents a bit before its leading edge.
   always_ff @(posedge link_clk_i) begin
      if (link_rst_i) begin
         mosi_q <= SBE_BIT_RST;
      end else if (go && xmode_q[2] == 1'b0) begin
         mosi_q <= xbyte_q[bit_pos(xmode_q[0], SBE_FIRST_BIT)]; // [RULE4]
      end else if (lead_tick && c_txph_q) begin
         mosi_q <= tbyte_q[bit_pos(c_order_q, k_q)];       // [RULE2]
      end else if (trail_tick && !c_txph_q && k_q != SBE_LAST_BIT) begin
         mosi_q <= tbyte_q[bit_pos(c_order_q, sbe_idx_t'(k_q + SBE_IDX_STEP))];
      end
   end

   // The pin reaches the second synchroniser stage two link cycles late, so
   // the sample strobe, its bit index and the end of byte are delayed to
   // match; fast preloads stay correct at the cost of two cycles per byte.
   assign samp_now = (lead_tick & ~c_rxph_q) | (trail_tick & c_rxph_q);

   always_ff @(posedge link_clk_i) begin
      if (link_rst_i || !en_l) begin
         samp_q  <= SBE_SYNC2_RST;
         fin_q   <= SBE_SYNC2_RST;
         sidx1_q <= SBE_FIRST_BIT;
         sidx2_q <= SBE_FIRST_BIT;
      end else begin
         samp_q  <= {samp_q[0], samp_now};
         fin_q   <= {fin_q[0], last};
         sidx1_q <= k_q;
         sidx2_q <= sidx1_q;
      end
   end

   // Data in is taken as it stood at the edge chosen by the receive phase.
   always_ff @(posedge link_clk_i) begin
      if (link_rst_i) begin
         rbyte_q <= SBE_BYTE_RST;
      end else if (samp_q[1]) begin
         rbyte_q[bit_pos(c_order_q, sidx2_q)] <= miso_sync_q[1]; // [RULE12]
      end
   end

   // The done toggle flips once the last sample has landed in rbyte.
   always_ff @(posedge link_clk_i) begin
      if (link_rst_i) begin
         done_tgl_q <= SBE_BIT_RST;
      end else if (fin_q[1]) begin
         done_tgl_q <= ~done_tgl_q;                        // [RULE9]
      end
   end

   // Pulse count kept only for checking.
   always_ff @(posedge link_clk_i) begin
      if (link_rst_i || go) begin
         pulse_q <= SBE_PULSE_RST;
      end else if (lead_tick) begin
         pulse_q <= sbe_pulse_t'(pulse_q + SBE_PULSE_STEP);
      end
   end

   assign serial_clock_pin_o = sclk_q;
   assign serial_out_pin_o   = mosi_q;

   // ---------------- Checks ----------------
   chk_disabled_flags: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE17]
      !block_enable_reg_i |=> tx_empty_flag_o && !rx_full_flag_o && !xfer_irq_o)
      else $error("flags not at idle values while disabled");
   chk_enable_gate: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
      !block_enable_reg_i |=> !busy_o)
      else $error("busy while disabled");
   chk_duplex_only: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
      duplex_select_i != SBE_FULL_DUPLEX |-> !sys_start)
      else $error("byte started outside full duplex");
   chk_write_clears: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
      block_enable_reg_i && tx_write_i |=> !tx_empty_flag_o)
      else $error("write did not clear transmit empty");
   chk_load_sets: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
      sys_start && !tx_write_i && block_enable_reg_i |=> tx_empty_flag_o && busy_o)
      else $error("load did not set transmit empty");
   chk_busy_wait: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
      busy_q && hold_v_q && block_enable_reg_i && !sys_done |=> hold_v_q)
      else $error("held byte consumed while shifting");
   chk_done_flags: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE9]
      sys_done |=> rx_full_flag_o && (xfer_irq_o == $past(irq_enable_i)))
      else $error("cycle end did not raise receive full");
   chk_pending_load: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE10]
      sys_done && hold_v_q && cnt_q == SBE_CNT_EMPTY && !rx_read_i
      && duplex_select_i == SBE_FULL_DUPLEX
      ##1 block_enable_reg_i |=> busy_o)
      else $error("pending byte not loaded after cycle end");
   chk_rx_capture: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE12]
      sys_done && cnt_q == SBE_CNT_EMPTY |=> rx_data_reg_o == $past(rbyte_q))
      else $error("receive register missed the sampled byte");
   chk_eight_pulses: assert property (@(posedge link_clk_i) disable iff (link_rst_i) // [RULE9]
      $changed(done_tgl_q) |-> pulse_q == SBE_PULSES)
      else $error("byte cycle ended without eight clock pulses");
   chk_msb_first: assert property (@(posedge link_clk_i) disable iff (link_rst_i) // [RULE4]
      lead_tick && k_q == SBE_FIRST_BIT && c_order_q == SBE_MSB_FIRST
      |=> mosi_q == tbyte_q[SBE_LAST_BIT])
      else $error("first bit out is not the top bit");
   chk_idle_clock: assert property (@(posedge link_clk_i) disable iff (link_rst_i) // [RULE15]
      state_q == SBE_IDLE && !go ##1 state_q == SBE_IDLE |-> sclk_q == $past(cpol_sync_q[1]))
      else $error("serial clock not at rest level while idle");
   chk_divider: assert property (@(posedge link_clk_i) disable iff (link_rst_i) // [RULE16]
      tick && state_q == SBE_SHIFT && !go |=> div_q == reload(c_pre_q))
      else $error("divider did not reload from preload");

endmodule : sbe_top
`default_nettype wire

// >>> verif/sbe_slave_model.sv
`timescale 1ns/1ns
`default_nettype none
module sbe_slave_model (
   input  wire logic               cs_n_i,
   input  wire logic               sclk_i,
   input  wire logic               mosi_i,
   input  wire sbe_pkg::sbe_byte_t reply_i,
   output logic                    miso_o,
   output sbe_pkg::sbe_byte_t      got_o,
   output var int                  bits_o
);
   import sbe_pkg::*;
   sbe_byte_t out_q;
   sbe_byte_t in_q;
   // Selection presents the first reply bit before any clock edge.
   always @(negedge cs_n_i) begin
      out_q = reply_i;
      bits_o = 0;
   end
   // Mode zero: the master's bit is taken on the rising edge.
   always @(posedge sclk_i) begin
      if (!cs_n_i) begin
         in_q = {in_q[6:0], mosi_i};
         bits_o = bits_o + 1;
         if (bits_o % 8 == 0) got_o = in_q;
      end
   end
   // The falling edge moves on; each new byte echoes the inverse of the last.
   always @(negedge sclk_i) begin
      if (!cs_n_i) out_q = (bits_o % 8 == 0) ? ~got_o : {out_q[6:0], 1'b0};
   end
   // A released line floats to its pull-up, so stale data never shows.
   assign miso_o = cs_n_i ? 1'b1 : out_q[7];
endmodule : sbe_slave_model
`default_nettype wire

// >>> verif/test_sbe_top.sv
`timescale 1ns/1ns
`default_nettype none
module test_sbe_top;
   import sbe_pkg::*;
   logic        clk = 1'b0, lclk = 1'b0, rst = 1'b1, lrst = 1'b1;
   logic        en = 1'b0, dup = 1'b0, wr = 1'b0, rd = 1'b0;
   logic        irq_en = 1'b0, cs_n = 1'b1;
   logic        tx_empty, rx_full, irq, busy, sclk, mosi, miso;
   sbe_pre_t    pre = 6'h01;
   sbe_byte_t   txd = 8'h00, reply = 8'h5A, rxd, got;
   sbe_byte_t   b[4];
   int          bits, error_cnt = 0, n_compared = 0, cyc = 0, hi = 0;
   int          f, i;
   logic [31:0] seed = 32'hC77A;
   // The link clock is offset so its edges never line up with the main one.
   always #2 clk = ~clk;
   initial begin
      #3;
      forever #16 lclk = ~lclk;
   end
   sbe_top i_dut (.clk_i(clk), .rst_i(rst), .link_clk_i(lclk),
      .link_rst_i(lrst), .block_enable_reg_i(en), .duplex_select_i(dup),
      .clock_polarity_sel_i(1'b0), .tx_clock_phase_i(1'b0),
      .rx_clock_phase_i(1'b0), .bit_order_sel_i(1'b0), .preload_i(pre),
      .irq_enable_i(irq_en), .tx_data_reg_i(txd), .tx_write_i(wr),
      .rx_read_i(rd), .serial_in_pin_i(miso), .tx_empty_flag_o(tx_empty),
      .rx_full_flag_o(rx_full), .rx_data_reg_o(rxd), .xfer_irq_o(irq),
      .busy_o(busy), .serial_clock_pin_o(sclk), .serial_out_pin_o(mosi));
   sbe_slave_model i_slave (.cs_n_i(cs_n), .sclk_i(sclk), .mosi_i(mosi),
      .reply_i(reply), .miso_o(miso), .got_o(got), .bits_o(bits));
   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] seen);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // Xorshift keeps the stimulus repeatable from its fixed seed.
   function automatic sbe_byte_t rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction : rnd
   task automatic put(input sbe_byte_t d, input logic exp_empty);
      @(negedge clk);
      txd = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      chk("tx empty after write", {7'h0, exp_empty}, {7'h0, tx_empty});
   endtask : put
   task automatic take(input sbe_byte_t exp);
      chk("rx data", exp, rxd);
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
   endtask : take
   // A byte written during a shift must stay held until that shift ends.
   task automatic wait_rx(input logic mon);
      for (i = 0; i < 3000 && rx_full !== 1'b1; i++) begin
         @(negedge clk);
         if (mon && busy === 1'b1 && rx_full === 1'b0) begin
            chk("held byte", 8'h00, {7'h0, tx_empty});
         end
      end
      // A byte that never ends counts as a mismatch here.
      if (rx_full !== 1'b1) begin
         chk("rx full", 8'h01, {7'h0, rx_full});
      end
   endtask : wait_rx
   task automatic wait_load;
      for (i = 0; i < 20 && tx_empty !== 1'b1; i++) @(negedge clk);
      chk("reload", 8'h03, {6'h0, busy, tx_empty});
   endtask : wait_load
   // One read sequence: command, two address bytes, one dummy byte.
   task automatic frame;
      cs_n = 1'b0;
      for (int k = 0; k < 4; k++) b[k] = (k == 0) ? 8'h03 : rnd();
      put(b[0], 1'b0);
      @(negedge clk);
      chk("load", 8'h03, {6'h0, busy, tx_empty});
      for (int k = 1; k <= 4; k++) begin
         if (k < 4) put(b[k], 1'b0);
         wait_rx(k < 4);
         chk("irq", {7'h0, irq_en}, {7'h0, irq});
         chk("slave got", b[k-1], got);
         if (k < 4) wait_load();
         take((k == 1) ? reply : ~b[k-2]);
         chk("rx full after read", 8'h00, {6'h0, rx_full, irq});
      end
      chk("pulses", 8'h20, 8'(bits));
      repeat (40) @(negedge clk);
      chk("idle after frame", 8'h00, {6'h0, busy, sclk});
      cs_n = 1'b1;
      // The slave must see the release before the next select.
      @(negedge clk);
   endtask : frame
   // Each high phase lasts the preload in link cycles, one for zero.
   always @(posedge lclk) begin
      if (sclk === 1'b1) begin
         hi++;
      end else if (hi != 0) begin
         chk("sclk high", (pre == 6'h00) ? 8'h01 : 8'(pre), 8'(hi));
         hi = 0;
      end
   end
   // The ceiling is far above the few thousand cycles the run needs.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         error_cnt++;
         end_of_test();
      end
   end
   initial begin
      repeat (10) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(posedge lclk);
      @(negedge lclk);
      lrst = 1'b0;
      repeat (4) @(negedge clk);
      chk("reset flags", 8'h04, {5'h0, tx_empty, rx_full, irq});
      put(8'hA5, 1'b1);
      repeat (20) @(negedge clk);
      chk("disabled", 8'h01, {5'h0, sclk, busy, tx_empty});
      en = 1'b1;
      dup = 1'b1;
      irq_en = 1'b1;
      put(8'h3C, 1'b0);
      repeat (20) @(negedge clk);
      chk("half duplex blocks", 8'h00, {7'h0, busy});
      en = 1'b0;
      repeat (2) @(negedge clk);
      chk("disable clears", 8'h04, {5'h0, tx_empty, rx_full, irq});
      dup = 1'b0;
      en = 1'b1;
      for (f = 0; f < 4; f++) begin
         pre = 6'(f);
         irq_en = f[0];
         reply = rnd();
         frame();
      end
      // Three bytes without reads: the third waits until a read frees a buffer entry.
      reply = rnd();
      cs_n = 1'b0;
      b[0] = rnd();
      b[1] = 8'h00;
      put(b[0], 1'b0);
      put(b[1], 1'b0);
      wait_rx(1'b1);
      wait_load();
      put(8'hFF, 1'b0);
      for (i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clk);
      repeat (100) @(negedge clk);
      chk("stalled byte", 8'h01, {5'h0, busy, tx_empty, rx_full});
      take(reply);
      take(~b[0]);
      wait_rx(1'b0);
      chk("third byte", ~b[1], rxd);
      en = 1'b0;
      repeat (2) @(negedge clk);
      chk("disable unread", 8'h04, {5'h0, tx_empty, rx_full, irq});
      cs_n = 1'b1;
      end_of_test();
   end
endmodule : test_sbe_top
`default_nettype wire
